// ### rtl/pbf_pkg.sv
// constants, codes and carrier types for the port b upper pin function select
// assumes a 16-bit register port and a single 10 MHz clock
package pbf_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] UPPER_FUNC_OFFSET = 4'h0;
  localparam logic [3:0] LOWER_FUNC_OFFSET = 4'h2;
  localparam logic [3:0] PIN_LEVEL_OFFSET = 4'h4;
  localparam logic [15:0] FUNC_RESET = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;
  localparam int SEL_W = 2;
  localparam int PINS = 8;

  // ----------------------------------------------------------------
  // selector codes and resolved pin kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_GPIO = 2'b00,
    SEL_IRQ = 2'b01,
    SEL_SERIAL = 2'b10,
    SEL_PATTERN = 2'b11
  } pbf_sel_t;

  typedef enum logic [2:0] {
    KIND_GPIO = 3'b000,
    KIND_IRQ = 3'b001,
    KIND_SCK = 3'b010,
    KIND_TXD = 3'b011,
    KIND_RXD = 3'b100,
    KIND_PAT = 3'b101,
    KIND_RSV = 3'b110
  } pbf_kind_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } pbf_bus_t;

  typedef struct packed {
    logic [7:0] gpio_out;
    logic [7:0] dir;
    logic [7:0] pattern;
    logic [1:0] sck_out;
    logic [1:0] txd;
  } pbf_periph_in_t;

  typedef struct packed {
    logic [7:0] gpio_in;
    logic [3:0] irq;
    logic [1:0] sck_in;
    logic [1:0] rxd;
  } pbf_periph_out_t;

  // idx is pin number minus 8
  function automatic pbf_kind_t pbf_pin_kind(input logic [2:0] idx, input pbf_sel_t code);
    pbf_kind_t k;
    k = KIND_RSV;
    unique case (code)
      SEL_GPIO: k = KIND_GPIO;
      SEL_IRQ: k = idx[2] ? KIND_IRQ : KIND_RSV;
      SEL_SERIAL:
      begin
        if (idx == 3'h4 || idx == 3'h5)
          k = KIND_SCK;
        else if (!idx[2])
          k = idx[0] ? KIND_TXD : KIND_RXD;
      end
      SEL_PATTERN: k = KIND_PAT;
    endcase
    return k;
  endfunction : pbf_pin_kind

  // serial channel served by a pin
  function automatic logic pbf_ch(input logic [2:0] idx);
    return idx[2] ? idx[0] : idx[1];
  endfunction : pbf_ch

endpackage : pbf_pkg

// ### rtl/pbf_upper_pin_func.sv
// pin function select for port b pins 15 to 8, plus storage of the lower-half selector
// assumes synchronous inputs, a register port with one-cycle read data,
// and that the lower-half mux and direction register live outside
`timescale 1ns/1ns

module pbf_upper_pin_func (
  input wire logic CLK_I, // 10 MHz clock
  input wire logic RST_B_I, // power-on reset, active low
  input wire pbf_pkg::pbf_bus_t BUS_I, // register request
  output logic [15:0] RDATA_O, // read data, cycle after strobe
  input wire logic [7:0] PIN_I, // pad levels, pins 15..8
  output logic [7:0] PIN_O, // pad output values
  output logic [7:0] PIN_OE_B_O, // pad enable, low drives
  input wire pbf_pkg::pbf_periph_in_t PERIPH_I, // peripheral signals toward pins
  output pbf_pkg::pbf_periph_out_t PERIPH_O, // pin levels toward peripherals
  output logic [15:0] LOWER_FUNC_O // lower-half selector for its mux
);
  import pbf_pkg::*;

  // ----------------------------------------------------------------
  // function select registers
  // ----------------------------------------------------------------
  logic [15:0] port_b_upper_pin_function;
  logic [15:0] port_b_lower_pin_function;
  logic wr_upper;
  logic wr_lower;

  assign wr_upper = BUS_I.we && BUS_I.addr == UPPER_FUNC_OFFSET;
  assign wr_lower = BUS_I.we && BUS_I.addr == LOWER_FUNC_OFFSET;

  // only the power-on reset pin clears these; manual reset, standby
  // and sleep never reach here, so settings survive them
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      port_b_upper_pin_function <= FUNC_RESET;
      port_b_lower_pin_function <= FUNC_RESET;
    end
    else
    begin
      if (wr_upper)
        port_b_upper_pin_function <= BUS_I.wdata;
      if (wr_lower)
        port_b_lower_pin_function <= BUS_I.wdata;
    end
  end

  assign LOWER_FUNC_O = port_b_lower_pin_function;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;

  always_comb
  begin
    next_rdata = READ_UNMAPPED;
    if (BUS_I.re)
    begin
      unique case (BUS_I.addr)
        UPPER_FUNC_OFFSET: next_rdata = port_b_upper_pin_function;
        LOWER_FUNC_OFFSET: next_rdata = port_b_lower_pin_function;
        PIN_LEVEL_OFFSET: next_rdata = {8'h00, PIN_I};
        default: next_rdata = READ_UNMAPPED;
      endcase
    end
  end

  // data holds only in the cycle after the strobe
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      RDATA_O <= 16'h0000;
    else
      RDATA_O <= next_rdata;
  end

  // ----------------------------------------------------------------
  // pin multiplexer
  // ----------------------------------------------------------------
  pbf_kind_t kind [PINS];
  logic [7:0] next_pin;
  logic [7:0] next_oe_b;
  logic [3:0] next_irq;
  logic [1:0] next_sck_in;
  logic [1:0] next_rxd;
  logic ch;

  // idle levels on unselected inputs are high, so a deselected
  // interrupt or receive line looks inactive, never a false edge
  always_comb
  begin
    next_pin = 8'h00;
    next_oe_b = 8'hff;
    next_irq = 4'hf;
    next_sck_in = 2'h3;
    next_rxd = 2'h3;
    ch = 1'b0;
    for (int i = 0; i < PINS; i++)
    begin
      kind[i] = pbf_pin_kind(3'(i),
        pbf_sel_t'(port_b_upper_pin_function[2*i +: SEL_W]));
      ch = pbf_ch(3'(i));
      unique case (kind[i])
        KIND_GPIO:
        begin
          next_oe_b[i] = !PERIPH_I.dir[i];
          next_pin[i] = PERIPH_I.gpio_out[i];
        end
        KIND_SCK:
        begin
          next_oe_b[i] = !PERIPH_I.dir[i];
          next_pin[i] = PERIPH_I.sck_out[ch];
          next_sck_in[ch] = PIN_I[i];
        end
        KIND_TXD:
        begin
          next_oe_b[i] = 1'b0;
          next_pin[i] = PERIPH_I.txd[ch];
        end
        KIND_RXD:
          next_rxd[ch] = PIN_I[i];
        KIND_IRQ:
          next_irq[2'(i)] = PIN_I[i];
        KIND_PAT:
        begin
          next_oe_b[i] = 1'b0;
          next_pin[i] = PERIPH_I.pattern[i];
        end
        KIND_RSV: ; // undriven; software must avoid these codes
        default: ;
      endcase
    end
  end

  // registered so pads never see decode glitches; costs one cycle
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      PIN_O <= 8'h00;
      PIN_OE_B_O <= 8'hff;
    end
    else
    begin
      PIN_O <= next_pin;
      PIN_OE_B_O <= next_oe_b;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      PERIPH_O.gpio_in <= 8'h00;
      PERIPH_O.irq <= 4'hf;
      PERIPH_O.sck_in <= 2'h3;
      PERIPH_O.rxd <= 2'h3;
    end
    else
    begin
      PERIPH_O.gpio_in <= PIN_I;
      PERIPH_O.irq <= next_irq;
      PERIPH_O.sck_in <= next_sck_in;
      PERIPH_O.rxd <= next_rxd;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  logic [15:0] up;
  assign up = port_b_upper_pin_function;

  a_reset_zero:
    assert property ($rose(RST_B_I) |-> up == 16'h0000 && LOWER_FUNC_O == 16'h0000)
    else $error("function registers not cleared by reset");

  a_write_takes:
    assert property (wr_upper |=> up == $past(BUS_I.wdata))
    else $error("upper write not stored");

  a_hold_no_write:
    assert property (!wr_upper && !wr_lower |=> $stable(up) && $stable(LOWER_FUNC_O))
    else $error("selector changed without a write");

  a_read_back:
    assert property (BUS_I.re && BUS_I.addr == LOWER_FUNC_OFFSET
      |=> RDATA_O == $past(LOWER_FUNC_O))
    else $error("lower read data wrong");

  a_pin15_reserved:
    assert property (up[15:14] == 2'b10 |=> PIN_OE_B_O[7] && PERIPH_O.irq[3])
    else $error("pin 15 reserved code drives or forwards");

  a_pin14_pattern:
    assert property (up[13:12] == 2'b11
      |=> !PIN_OE_B_O[6] && PIN_O[6] == $past(PERIPH_I.pattern[6]))
    else $error("pin 14 pattern not driven");

  a_pin13_clock:
    assert property (up[11:10] == 2'b10 |=> PERIPH_O.sck_in[1] == $past(PIN_I[5])
      && PIN_OE_B_O[5] == !$past(PERIPH_I.dir[5]))
    else $error("pin 13 serial clock wrong");

  a_pin12_irq:
    assert property (up[9:8] == 2'b01
      |=> PERIPH_O.irq[0] == $past(PIN_I[4]) && PIN_OE_B_O[4])
    else $error("pin 12 interrupt not forwarded");

  a_pin11_txd:
    assert property (up[7:6] == 2'b10
      |=> !PIN_OE_B_O[3] && PIN_O[3] == $past(PERIPH_I.txd[1]))
    else $error("pin 11 transmit wrong");

  a_pin10_rxd:
    assert property (up[5:4] == 2'b10
      |=> PERIPH_O.rxd[1] == $past(PIN_I[2]) && PIN_OE_B_O[2])
    else $error("pin 10 receive wrong");

  a_pin9_txd:
    assert property (up[3:2] == 2'b10
      |=> !PIN_OE_B_O[1] && PIN_O[1] == $past(PERIPH_I.txd[0]))
    else $error("pin 9 transmit wrong");

  a_pin8_rxd:
    assert property (up[1:0] == 2'b10 ##1 up[1:0] == 2'b10
      |-> PERIPH_O.rxd[0] == $past(PIN_I[0]) && PIN_OE_B_O[0])
    else $error("pin 8 receive wrong");

  a_gpio_dir:
    assert property (up[15:14] == 2'b00
      |=> PIN_OE_B_O[7] == !$past(PERIPH_I.dir[7]) && PIN_O[7] == $past(PERIPH_I.gpio_out[7]))
    else $error("pin 15 gpio direction wrong");

  a_input_no_drive:
    assert property (up[13:12] == 2'b01 |=> PIN_OE_B_O[6] && PERIPH_O.irq[2] == $past(PIN_I[6]))
    else $error("pin 14 interrupt input drives pad");

  a_rdata_idle:
    assert property (!BUS_I.re |=> RDATA_O == 16'h0000)
    else $error("read data not cleared after strobe");

  a_read_upper:
    assert property (BUS_I.re && BUS_I.addr == UPPER_FUNC_OFFSET
      |=> RDATA_O == $past(up))
    else $error("upper read data wrong");

  a_lower_write:
    assert property (wr_lower |=> LOWER_FUNC_O == $past(BUS_I.wdata))
    else $error("lower write not stored");

  a_pin15_irq:
    assert property (up[15:14] == 2'b01
      |=> PERIPH_O.irq[3] == $past(PIN_I[7]) && PIN_OE_B_O[7])
    else $error("pin 15 interrupt not forwarded");

  a_pin15_pattern:
    assert property (up[15:14] == 2'b11
      |=> !PIN_OE_B_O[7] && PIN_O[7] == $past(PERIPH_I.pattern[7]))
    else $error("pin 15 pattern not driven");

  a_pin13_irq:
    assert property (up[11:10] == 2'b01
      |=> PERIPH_O.irq[1] == $past(PIN_I[5]) && PIN_OE_B_O[5])
    else $error("pin 13 interrupt not forwarded");

  a_pin12_clock:
    assert property (up[9:8] == 2'b10 |=> PERIPH_O.sck_in[0] == $past(PIN_I[4])
      && PIN_OE_B_O[4] == !$past(PERIPH_I.dir[4])
      && PIN_O[4] == $past(PERIPH_I.sck_out[0]))
    else $error("pin 12 serial clock wrong");

  a_pin8_pattern:
    assert property (up[1:0] == 2'b11
      |=> !PIN_OE_B_O[0] && PIN_O[0] == $past(PERIPH_I.pattern[0]))
    else $error("pin 8 pattern not driven");

  a_irq_idle:
    assert property (up[15:14] != 2'b01 |=> PERIPH_O.irq[3])
    else $error("pin 15 interrupt forwarded while not selected");

  a_gpio_in_follow:
    assert property (1'b1 |=> PERIPH_O.gpio_in == $past(PIN_I))
    else $error("pin levels not forwarded");

endmodule : pbf_upper_pin_func

// ### verif/pbf_upper_pin_func_tb.sv
// bench for the port b upper pin function select, with a reference model
// assumes pbf_pkg and the design compiled first; the bench drives every port
`timescale 1ns/1ns
module pbf_upper_pin_func_tb;
  import pbf_pkg::*;
  logic CLK_I;
  logic RST_B_I;
  pbf_bus_t BUS_I;
  logic [15:0] RDATA_O;
  logic [7:0] PIN_I;
  logic [7:0] PIN_O;
  logic [7:0] PIN_OE_B_O;
  pbf_periph_in_t PERIPH_I;
  pbf_periph_out_t PERIPH_O;
  logic [15:0] LOWER_FUNC_O;
  int num_errors = 0;
  int total_checks = 0;
  logic [15:0] rnd = 16'h98b8;

  pbf_upper_pin_func i_dut (
    .CLK_I(CLK_I),
    .RST_B_I(RST_B_I),
    .BUS_I(BUS_I),
    .RDATA_O(RDATA_O),
    .PIN_I(PIN_I),
    .PIN_O(PIN_O),
    .PIN_OE_B_O(PIN_OE_B_O),
    .PERIPH_I(PERIPH_I),
    .PERIPH_O(PERIPH_O),
    .LOWER_FUNC_O(LOWER_FUNC_O)
  );

  initial
  begin
    CLK_I = 1'b0;
    forever #50 CLK_I = ~CLK_I;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // reserved codes become gpio; the pin behaviour there is undefined
  function automatic logic [15:0] legal(input logic [15:0] s);
    for (int i = 0; i < 8; i++)
      if ((s[2*i+:2] == 2'b01 && i < 4) || (s[2*i+:2] == 2'b10 && i >= 6))
        s[2*i+:2] = 2'b00;
    return s;
  endfunction : legal

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // strobe stays up until the next task or idle replaces it
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    BUS_I <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge CLK_I);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    BUS_I <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
    @(posedge CLK_I);
    BUS_I <= '0;
    @(negedge CLK_I);
    d = RDATA_O;
    @(posedge CLK_I);
  endtask : rd

  task automatic idle(input int n);
    BUS_I <= '0;
    repeat (n) @(posedge CLK_I);
  endtask : idle

  // ----------------------------------------------------------------
  // reference model of the pin mux
  // ----------------------------------------------------------------
  task automatic run_mux(input logic [15:0] s);
    logic [7:0] oe;
    logic [7:0] po;
    logic [3:0] irq;
    logic [1:0] sck;
    logic [1:0] rxd;
    logic [27:0] pv;
    logic [15:0] d;
    s = legal(s);
    wr(UPPER_FUNC_OFFSET, s);
    rnd = lfsr(rnd);
    pv = {rnd[11:0], lfsr(rnd)};
    rnd = lfsr(lfsr(rnd));
    PIN_I <= rnd[7:0];
    PERIPH_I <= pv;
    idle(3);
    @(negedge CLK_I);
    oe = 8'hff;
    po = 8'h00;
    irq = 4'hf;
    sck = 2'h3;
    rxd = 2'h3;
    for (int i = 0; i < 8; i++)
      case (s[2*i+:2])
        2'b00: {oe[i], po[i]} = {~PERIPH_I.dir[i], PERIPH_I.gpio_out[i]};
        2'b01: if (i >= 4) irq[i-4] = PIN_I[i];
        2'b10:
        begin
          if (i >= 4)
            {oe[i], po[i], sck[i-4]} = {~PERIPH_I.dir[i], PERIPH_I.sck_out[i-4], PIN_I[i]};
          else if (i % 2 == 1)
            {oe[i], po[i]} = {1'b0, PERIPH_I.txd[i/2]};
          else
            rxd[i/2] = PIN_I[i];
        end
        default: {oe[i], po[i]} = {1'b0, PERIPH_I.pattern[i]};
      endcase
    chk(16'(PIN_OE_B_O), 16'(oe));
    chk(16'(PIN_O & ~oe), 16'(po & ~oe));
    chk(16'(PERIPH_O.irq), 16'(irq));
    chk(16'({PERIPH_O.sck_in, PERIPH_O.rxd}), 16'({sck, rxd}));
    chk(16'(PERIPH_O.gpio_in), 16'(PIN_I));
    @(posedge CLK_I);
    rd(UPPER_FUNC_OFFSET, d);
    chk(d, s);
  endtask : run_mux

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] d;
    logic [15:0] up;
    BUS_I = '0;
    PIN_I = 8'h00;
    PERIPH_I = '0;
    RST_B_I = 1'b0;
    repeat (3) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    @(posedge CLK_I);
    rd(UPPER_FUNC_OFFSET, d);
    chk(d, FUNC_RESET);
    rd(LOWER_FUNC_OFFSET, d);
    chk(d, FUNC_RESET);
    $display("test reset values done");
    for (int c = 0; c < 4; c++)
      run_mux({8{2'(c)}});
    repeat (24)
    begin
      rnd = lfsr(rnd);
      run_mux(rnd);
    end
    $display("test pin functions done");
    up = legal(lfsr(rnd));
    wr(UPPER_FUNC_OFFSET, up);
    wr(LOWER_FUNC_OFFSET, 16'ha5c3);
    wr(PIN_LEVEL_OFFSET, 16'hffff);
    wr(4'h6, 16'hffff);
    rd(LOWER_FUNC_OFFSET, d);
    chk(d, 16'ha5c3);
    chk(LOWER_FUNC_O, 16'ha5c3);
    rd(4'h6, d);
    chk(d, READ_UNMAPPED);
    rd(PIN_LEVEL_OFFSET, d);
    chk(d, {8'h00, PIN_I});
    idle(50);
    rd(UPPER_FUNC_OFFSET, d);
    chk(d, up);
    $display("test register access done");
    // second power-on reset in mid-run
    RST_B_I <= 1'b0;
    @(negedge CLK_I);
    chk(LOWER_FUNC_O, FUNC_RESET);
    chk(16'({PIN_OE_B_O, PERIPH_O.irq}), 16'h0fff);
    @(posedge CLK_I);
    RST_B_I <= 1'b1;
    @(posedge CLK_I);
    rd(UPPER_FUNC_OFFSET, d);
    chk(d, FUNC_RESET);
    run_mux(16'h0000);
    $display("test second reset done");
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge CLK_I);
    num_errors++;
    end_of_test();
  end
endmodule : pbf_upper_pin_func_tb
